// File: hw/ecc_pkg.sv
// Shared constants and types for the flash array SECDED ECC block
// Notes on behaviour
// - Check codes cover aligned 16-byte data units of the array.
// - Moving a unit into an erased line stores its hidden check code.
// - Reads of a unit with a valid code and ECC on check the stored code and fix single-bit errors.
// - In single-bit mode, a first program of any amount sets the code for the whole unit.
// - Single-bit mode: reprogramming a unit disables its ECC, sets off flag.
// - Only a sector erase or a reset re-enables ECC on a disabled unit.
// - 16 bytes is the least granule keeping ECC; filling a unit in parts loses protection.
// - Double-bit detection mode is the default; it also reports 2-bit errors.
// - Double-bit mode stores and checks a 9-bit code instead of 8 bits.
// - Double-bit mode rejects byte programs and reprograms with program error.
// - A mode change either way invalidates every stored check code.
// - Volatile 16-bit error counter read as low and high byte.
// - Volatile 32-bit error address trap read as four bytes.
// - Trap takes the first error address after reset and holds it.
// - Counter steps on each single- or double-bit error found on reads until it saturates at 16'hffff.
package ecc_pkg;
	localparam int          UNIT_BYTES    = 16;
	localparam int          UNIT_LSB      = 4;
	localparam int          DATA_W        = 128;
	localparam int          HAM_W         = 8;
	localparam int          CHK_W         = 9;
	localparam int          CODE_LEN      = 136;
	localparam logic [31:0] OFS_TRAP_B2   = 32'h0080_0040;
	localparam logic [31:0] OFS_TRAP_B3   = 32'h0080_0041;
	localparam logic [31:0] OFS_STATUS    = 32'h0080_0089;
	localparam logic [31:0] OFS_COUNT_LO  = 32'h0080_008a;
	localparam logic [31:0] OFS_COUNT_HI  = 32'h0080_008b;
	localparam logic [31:0] OFS_TRAP_B0   = 32'h0080_008e;
	localparam logic [31:0] OFS_TRAP_B1   = 32'h0080_008f;
	localparam int          ST_DBL_POS    = 3;
	localparam int          ST_SGL_POS    = 1;
	localparam int          ST_OFF_POS    = 0;
	localparam logic [7:0]  STATUS_RST    = 8'h00;
	localparam logic [15:0] COUNT_RST     = 16'h0000;
	localparam logic [15:0] COUNT_MAX     = 16'hffff;
	localparam logic [31:0] TRAP_RST      = 32'h0000_0000;
	localparam logic        MODE_RST      = 1'b1;
	localparam logic [7:0]  ERASED_BYTE   = 8'hff;
	localparam logic [7:0]  UNMAPPED_BYTE = 8'h00;

	// Per-unit outcome of one array read
	typedef struct packed {
		logic dbl;
		logic sgl;
		logic off;
	} unit_flags_t;
endpackage : ecc_pkg

// File: hw/secded_codec.sv
// Hamming SECDED encoder and checker for one 128-bit data unit
`timescale 1ns/1ps
module secded_codec (
	input  wire logic [ecc_pkg::DATA_W-1:0] data_i,
	input  wire logic [ecc_pkg::CHK_W-1:0]  chk_i,
	input  wire logic                       dbl_mode_i,
	output logic      [ecc_pkg::CHK_W-1:0]  chk_o,
	output logic      [ecc_pkg::DATA_W-1:0] data_o,
	output logic                            sgl_o,
	output logic                            dbl_o
);
	// Data bits fill the non-power-of-two code positions 3..136
	always_comb
	begin
		int k;
		logic [ecc_pkg::HAM_W-1:0] syn;
		logic par;
		k = 0;
		syn = '0;
		par = 1'b0;
		chk_o = '0;
		data_o = data_i;
		for (int p = 1; p <= ecc_pkg::CODE_LEN; p++)
			if ((p & (p - 1)) != 0)
			begin
				for (int j = 0; j < ecc_pkg::HAM_W; j++)
					if (p[j])
						chk_o[j] = chk_o[j] ^ data_i[k];
				k++;
			end
		// Overall parity bit, only stored in double-bit mode
		chk_o[ecc_pkg::HAM_W] = ^data_i ^ ^chk_o[ecc_pkg::HAM_W-1:0];
		syn = chk_o[ecc_pkg::HAM_W-1:0] ^ chk_i[ecc_pkg::HAM_W-1:0];
		par = ^data_i ^ ^chk_i;
		if (dbl_mode_i)
		begin
			sgl_o = par;
			dbl_o = !par && (syn != '0);
		end
		else
		begin
			sgl_o = (syn != '0);
			dbl_o = 1'b0;
		end
		// Flip the data bit the syndrome points at; check-bit hits need none
		k = 0;
		for (int p = 1; p <= ecc_pkg::CODE_LEN; p++)
			if ((p & (p - 1)) != 0)
			begin
				if (sgl_o && syn == ecc_pkg::HAM_W'(p))
					data_o[k] = !data_i[k];
				k++;
			end
	end
endmodule : secded_codec

// File: hw/flash_array_secded_ecc.sv
// Array ECC engine: code store, program checks, read fixes, error regs
`timescale 1ns/1ps
module flash_array_secded_ecc #(
	parameter int UNITS     = 64,
	parameter int UNITS_SEC = 16
) (
	input  wire logic                       ref_clk_i,
	input  wire logic                       srst_i,
	input  wire logic                       dbl_mode_i,
	input  wire logic                       erase_valid_i,
	input  wire logic [31:0]                erase_addr_i,
	input  wire logic                       prog_valid_i,
	input  wire logic [31:0]                prog_addr_i,
	input  wire logic [ecc_pkg::DATA_W-1:0] prog_data_i,
	input  wire logic [ecc_pkg::UNIT_BYTES-1:0] prog_mask_i,
	output logic                            prog_done_o,
	output logic                            prog_err_o,
	input  wire logic                       rd_valid_i,
	input  wire logic [31:0]                rd_addr_i,
	input  wire logic [ecc_pkg::DATA_W-1:0] rd_raw_i,
	output logic                            rd_valid_o,
	output logic      [ecc_pkg::DATA_W-1:0] rd_data_o,
	output ecc_pkg::unit_flags_t            rd_flags_o,
	input  wire logic                       reg_rd_i,
	input  wire logic [31:0]                reg_addr_i,
	output logic                            reg_rvalid_o,
	output logic      [7:0]                 reg_rdata_o
);
	localparam int UNIT_AW = (UNITS > 1) ? $clog2(UNITS) : 1;
	localparam int SEC_SH  = $clog2(UNITS_SEC);

	// Unit index of a byte address; one slice shared by all three paths
	function automatic logic [UNIT_AW-1:0] unit_of(input logic [31:0] a);
		return a[ecc_pkg::UNIT_LSB +: UNIT_AW];
	endfunction : unit_of

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);

	// Per-unit bookkeeping kept in hidden array space
	logic [UNITS-1:0]           prog_q;
	logic [UNITS-1:0]           off_q;
	logic [UNITS-1:0]           cv_q;
	logic [ecc_pkg::CHK_W-1:0]  chk_mem [UNITS];
	logic                       mode_q;
	logic [7:0]                 status_q;
	logic [15:0]                count_q;
	logic [31:0]                trap_q;
	logic                       trap_hit_q;

	logic [UNIT_AW-1:0]         p_unit;
	logic [UNIT_AW-1:0]         r_unit;
	logic [UNITS-1:0]           sect_hit;
	logic                       prog_take;
	logic                       rd_take;
	logic                       mode_chg;
	logic                       p_first;
	logic                       p_err;
	logic [ecc_pkg::DATA_W-1:0] p_merged;
	logic [ecc_pkg::CHK_W-1:0]  p_chk;
	logic [ecc_pkg::CHK_W-1:0]  p_store;
	logic [ecc_pkg::DATA_W-1:0] r_fixed;
	logic                       r_sgl;
	logic                       r_dbl;
	logic                       r_active;
	ecc_pkg::unit_flags_t       r_flags;

	// One operation per cycle; erase beats program beats read
	assign prog_take = prog_valid_i && !erase_valid_i;
	assign rd_take   = rd_valid_i && !erase_valid_i && !prog_valid_i;
	assign mode_chg  = dbl_mode_i != mode_q;

	// Units are aligned 16-byte slices of the byte address
	assign p_unit = unit_of(prog_addr_i);
	assign r_unit = unit_of(rd_addr_i);

	// Units sharing the erased sector
	always_comb
	begin
		for (int u = 0; u < UNITS; u++)
			sect_hit[u] = ((u >> SEC_SH) ==
				int'(unit_of(erase_addr_i) >> SEC_SH));
	end

	// Bytes outside the mask stay erased, so the code covers all 16
	always_comb
	begin
		for (int b = 0; b < ecc_pkg::UNIT_BYTES; b++)
			p_merged[8*b +: 8] = prog_mask_i[b] ? prog_data_i[8*b +: 8]
				: ecc_pkg::ERASED_BYTE;
	end

	// Encoder for the program path
	secded_codec u_enc (
		.data_i     (p_merged),
		.chk_i      ('0),
		.dbl_mode_i (dbl_mode_i),
		.chk_o      (p_chk),
		.data_o     (),
		.sgl_o      (),
		.dbl_o      ()
	);

	// Single-bit mode keeps only the 8 Hamming bits
	assign p_store = dbl_mode_i ? p_chk
		: {1'b0, p_chk[ecc_pkg::HAM_W-1:0]};

	// Double-bit mode refuses partial units and second programs
	assign p_first = !prog_q[p_unit];
	assign p_err   = dbl_mode_i && (!p_first || !(&prog_mask_i));

	// Checker for the read path
	secded_codec u_chk (
		.data_i     (rd_raw_i),
		.chk_i      (chk_mem[r_unit]),
		.dbl_mode_i (dbl_mode_i),
		.chk_o      (),
		.data_o     (r_fixed),
		.sgl_o      (r_sgl),
		.dbl_o      (r_dbl)
	);

	// A unit is checked only with a valid code and ECC still on
	assign r_active = prog_q[r_unit] && cv_q[r_unit] && !off_q[r_unit];

	always_comb
	begin
		r_flags.off = off_q[r_unit] || (prog_q[r_unit] && !cv_q[r_unit]);
		r_flags.sgl = r_active && r_sgl;
		r_flags.dbl = r_active && r_dbl && dbl_mode_i;
	end

	// Mode follower; powers up in double-bit detection
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
			mode_q <= ecc_pkg::MODE_RST;
		else
			mode_q <= dbl_mode_i;
	end

	// Programmed and disabled flags per unit
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			prog_q <= '0;
			off_q  <= '0;
		end
		else if (erase_valid_i)
		begin
			prog_q <= prog_q & ~sect_hit;
			off_q  <= off_q & ~sect_hit;
		end
		else if (prog_take && !p_err)
		begin
			prog_q[p_unit] <= 1'b1;
			if (!p_first)
				off_q[p_unit] <= 1'b1;
		end
	end

	// Code-valid flags; a mode change voids every code at once
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
			cv_q <= '0;
		else if (mode_chg)
			cv_q <= '0;
		else if (erase_valid_i)
			cv_q <= cv_q & ~sect_hit;
		else if (prog_take && !p_err && p_first)
			cv_q[p_unit] <= 1'b1;
	end

	// Hidden code storage, no reset needed: cv_q guards every use
	always_ff @(posedge ref_clk_i)
	begin
		if (prog_take && !p_err && p_first)
			chk_mem[p_unit] <= p_store;
	end

	// Program answer one cycle after the request
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			prog_done_o <= 1'b0;
			prog_err_o  <= 1'b0;
		end
		else
		begin
			prog_done_o <= prog_take;
			prog_err_o  <= prog_take && p_err;
		end
	end

	// Corrected read data, one cycle latency
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			rd_valid_o <= 1'b0;
			rd_data_o  <= '0;
			rd_flags_o <= '0;
		end
		else
		begin
			rd_valid_o <= rd_take;
			if (rd_take)
			begin
				rd_data_o  <= r_active ? r_fixed : rd_raw_i;
				rd_flags_o <= r_flags;
			end
		end
	end

	// Status tracks the last read unit only
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
			status_q <= ecc_pkg::STATUS_RST;
		else if (rd_take)
		begin
			status_q <= ecc_pkg::STATUS_RST;
			status_q[ecc_pkg::ST_DBL_POS] <= r_flags.dbl;
			status_q[ecc_pkg::ST_SGL_POS] <= r_flags.sgl;
			status_q[ecc_pkg::ST_OFF_POS] <= r_flags.off;
		end
	end

	// Saturating tally, so a long run never wraps to a clean zero
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
			count_q <= ecc_pkg::COUNT_RST;
		else if (rd_take && (r_flags.sgl || r_flags.dbl)
			&& count_q != ecc_pkg::COUNT_MAX)
			count_q <= count_q + 16'h0001;
	end

	// First failing address after reset, frozen afterwards
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			trap_q     <= ecc_pkg::TRAP_RST;
			trap_hit_q <= 1'b0;
		end
		else if (rd_take && !trap_hit_q && (r_flags.sgl || r_flags.dbl))
		begin
			trap_q     <= rd_addr_i;
			trap_hit_q <= 1'b1;
		end
	end

	// Byte-wide register reads, answered next cycle
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			reg_rvalid_o <= 1'b0;
			reg_rdata_o  <= ecc_pkg::UNMAPPED_BYTE;
		end
		else
		begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i)
				unique case (reg_addr_i)
					ecc_pkg::OFS_STATUS:   reg_rdata_o <= status_q;
					ecc_pkg::OFS_COUNT_LO: reg_rdata_o <= count_q[7:0];
					ecc_pkg::OFS_COUNT_HI: reg_rdata_o <= count_q[15:8];
					ecc_pkg::OFS_TRAP_B0:  reg_rdata_o <= trap_q[7:0];
					ecc_pkg::OFS_TRAP_B1:  reg_rdata_o <= trap_q[15:8];
					ecc_pkg::OFS_TRAP_B2:  reg_rdata_o <= trap_q[23:16];
					ecc_pkg::OFS_TRAP_B3:  reg_rdata_o <= trap_q[31:24];
					default:               reg_rdata_o <= ecc_pkg::UNMAPPED_BYTE;
				endcase
		end
	end

	// Checks on program, erase and mode-change handling
	a_dbl_reject: assert property (
		prog_take && dbl_mode_i && (prog_q[p_unit] || !(&prog_mask_i))
		|=> prog_done_o && prog_err_o)
		else $error("double-bit mode program not rejected");
	a_sgl_reprog_off: assert property (
		prog_take && !dbl_mode_i && prog_q[p_unit]
		|=> off_q[$past(p_unit)] && !prog_err_o)
		else $error("reprogram did not disable unit ECC");
	a_first_code: assert property (
		prog_take && p_first && !p_err && !mode_chg
		|=> cv_q[$past(p_unit)] && chk_mem[$past(p_unit)] == $past(p_store))
		else $error("first program did not store check code");
	a_erase_clears: assert property (
		erase_valid_i |=> ((prog_q | off_q | cv_q) & $past(sect_hit)) == '0)
		else $error("erase left unit flags set");
	a_mode_inval: assert property (
		mode_chg |=> cv_q == '0)
		else $error("mode change kept a check code");

	// Checks on read reporting and single-bit program acceptance
	a_rd_answer: assert property (
		rd_take |=> rd_valid_o
			&& rd_flags_o.sgl == $past(r_active && r_sgl)
			&& status_q[ecc_pkg::ST_SGL_POS] == rd_flags_o.sgl)
		else $error("read answer or status wrong");
	a_count_step: assert property (
		rd_take && (r_flags.sgl || r_flags.dbl)
		&& count_q != ecc_pkg::COUNT_MAX
		|=> count_q == $past(count_q) + 16'h0001)
		else $error("error counter did not step");
	a_trap_hold: assert property (
		trap_hit_q |=> trap_hit_q && $stable(trap_q))
		else $error("error trap changed after capture");
	a_status_hold: assert property (
		!rd_take |=> $stable(status_q))
		else $error("status changed without a read");
	a_reg_answer: assert property (
		reg_rd_i && reg_addr_i == ecc_pkg::OFS_COUNT_HI
		|=> reg_rvalid_o && reg_rdata_o == $past(count_q[15:8]))
		else $error("count high byte read wrong");
	a_off_raw: assert property (
		rd_take && !r_active |=> rd_data_o == $past(rd_raw_i))
		else $error("unchecked unit did not return raw data");
	a_trap_first: assert property (
		rd_take && !trap_hit_q && (r_flags.sgl || r_flags.dbl)
		|=> trap_hit_q && trap_q == $past(rd_addr_i))
		else $error("error trap missed the first failing read");
	a_sgl_no_dbl: assert property (
		rd_take && !dbl_mode_i
		|=> !rd_flags_o.dbl && !status_q[ecc_pkg::ST_DBL_POS])
		else $error("double-bit flag raised in single-bit mode");
	a_sgl_partial_ok: assert property (
		prog_take && !dbl_mode_i |=> prog_done_o && !prog_err_o)
		else $error("single-bit mode program was rejected");

	// Main scenarios
	c_sgl_fix: cover property (rd_take && r_flags.sgl);
	c_dbl_found: cover property (rd_take && r_flags.dbl);
	c_reprog_off: cover property (
		prog_take && !dbl_mode_i && prog_q[p_unit]);
	c_erase_after_off: cover property (erase_valid_i && |(off_q & sect_hit));
	c_mode_switch: cover property (mode_chg && |prog_q);
endmodule : flash_array_secded_ecc

// File: sim/flash_line_model.sv
// Flash array line store that feeds raw unit data to the ECC block
`timescale 1ns/1ps
module flash_line_model #(
	parameter int UNITS     = 8,
	parameter int UNITS_SEC = 4
) (
	input  wire logic                       ref_clk_i,
	input  wire logic                       erase_valid_i,
	input  wire logic [31:0]                erase_addr_i,
	input  wire logic                       prog_valid_i,
	input  wire logic [31:0]                prog_addr_i,
	input  wire logic [ecc_pkg::DATA_W-1:0] prog_data_i,
	input  wire logic [15:0]                prog_mask_i,
	input  wire logic                       prog_done_i,
	input  wire logic                       prog_err_i,
	input  wire logic [31:0]                rd_addr_i,
	input  wire logic [ecc_pkg::DATA_W-1:0] flip_i,
	output logic      [ecc_pkg::DATA_W-1:0] rd_raw_o
);
	localparam int UW = $clog2(UNITS);
	localparam int SW = $clog2(UNITS_SEC);
	logic [ecc_pkg::DATA_W-1:0] line_q [UNITS];
	logic [ecc_pkg::DATA_W-1:0] pend_q;
	logic [UW-1:0]              pend_unit_q;

	// Array ships erased
	initial
	begin
		foreach (line_q[u])
			line_q[u] = '1;
	end

	// Cells only fall from 1 to 0; a refused program leaves the line alone
	always @(posedge ref_clk_i)
	begin
		if (prog_valid_i)
		begin
			pend_unit_q <= prog_addr_i[4 +: UW];
			for (int b = 0; b < 16; b++)
				pend_q[8*b +: 8] <= prog_mask_i[b] ? prog_data_i[8*b +: 8] : 8'hff;
		end
		if (prog_done_i && !prog_err_i)
			line_q[pend_unit_q] <= line_q[pend_unit_q] & pend_q;
		if (erase_valid_i)
			foreach (line_q[u])
				if ((u >> SW) == (erase_addr_i[4 +: UW] >> SW))
					line_q[u] <= '1;
	end

	// Injected flips stand in for worn cells
	assign rd_raw_o = line_q[rd_addr_i[4 +: UW]] ^ flip_i;
endmodule : flash_line_model

// File: sim/flash_array_secded_ecc_tb_top.sv
// Self-checking bench for the array ECC block with a line store model
`timescale 1ns/1ps
module flash_array_secded_ecc_tb_top;
	localparam int     UN = 8;
	localparam int     US = 4;
	localparam [31:0]  HI = 32'h0312_0005;
	logic              ref_clk_i = 1'b0;
	logic              srst_i = 1'b1;
	logic              dbl_mode_i = 1'b1;
	logic              erase_valid_i = 1'b0;
	logic [31:0]       erase_addr_i = '0;
	logic              prog_valid_i = 1'b0;
	logic [31:0]       prog_addr_i = '0;
	logic [127:0]      prog_data_i = '0;
	logic [15:0]       prog_mask_i = '0;
	logic              rd_valid_i = 1'b0;
	logic [31:0]       rd_addr_i = '0;
	logic [127:0]      rd_raw_i;
	logic [127:0]      flip = '0;
	logic              reg_rd_i = 1'b0;
	logic [31:0]       reg_addr_i = '0;
	logic              prog_done_o;
	logic              prog_err_o;
	logic              rd_valid_o;
	logic [127:0]      rd_data_o;
	ecc_pkg::unit_flags_t rd_flags_o;
	logic              reg_rvalid_o;
	logic [7:0]        reg_rdata_o;
	int                mismatches = 0;
	int                compares = 0;
	logic [31:0]       seed = 32'h2404;
	logic              exp_prog [$];
	logic [130:0]      exp_rd [$];
	logic              exp_dc [$];
	logic [7:0]        exp_reg [$];
	logic [31:0]       ofs [8] = '{ecc_pkg::OFS_STATUS, ecc_pkg::OFS_COUNT_LO,
		ecc_pkg::OFS_COUNT_HI, ecc_pkg::OFS_TRAP_B0, ecc_pkg::OFS_TRAP_B1,
		ecc_pkg::OFS_TRAP_B2, ecc_pkg::OFS_TRAP_B3, 32'h0080_0090};

	flash_array_secded_ecc #(.UNITS(UN), .UNITS_SEC(US)) DUT (
		.ref_clk_i(ref_clk_i), .srst_i(srst_i), .dbl_mode_i(dbl_mode_i),
		.erase_valid_i(erase_valid_i), .erase_addr_i(erase_addr_i),
		.prog_valid_i(prog_valid_i), .prog_addr_i(prog_addr_i),
		.prog_data_i(prog_data_i), .prog_mask_i(prog_mask_i),
		.prog_done_o(prog_done_o), .prog_err_o(prog_err_o),
		.rd_valid_i(rd_valid_i), .rd_addr_i(rd_addr_i),
		.rd_raw_i(rd_raw_i), .rd_valid_o(rd_valid_o),
		.rd_data_o(rd_data_o), .rd_flags_o(rd_flags_o),
		.reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
		.reg_rvalid_o(reg_rvalid_o), .reg_rdata_o(reg_rdata_o));
	flash_line_model #(.UNITS(UN), .UNITS_SEC(US)) M (
		.ref_clk_i(ref_clk_i), .erase_valid_i(erase_valid_i),
		.erase_addr_i(erase_addr_i), .prog_valid_i(prog_valid_i),
		.prog_addr_i(prog_addr_i), .prog_data_i(prog_data_i),
		.prog_mask_i(prog_mask_i), .prog_done_i(prog_done_o),
		.prog_err_i(prog_err_o), .rd_addr_i(rd_addr_i), .flip_i(flip),
		.rd_raw_o(rd_raw_i));

	// 125 MHz clock
	initial
	begin
		forever #4 ref_clk_i = ~ref_clk_i;
	end

	function automatic logic [127:0] r128();
		logic [127:0] v;
		v = '0;
		for (int i = 0; i < 4; i++)
		begin
			seed ^= seed << 13;
			seed ^= seed >> 17;
			seed ^= seed << 5;
			v = {v[95:0], seed};
		end
		return v;
	endfunction : r128

	task automatic check(string what, logic [130:0] e, logic [130:0] g);
		compares++;
		if (g !== e)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask : check

	// Registered answers are sampled one edge after their request
	always @(posedge ref_clk_i)
	begin
		if (prog_done_o === 1'b1)
			check("prog_err", exp_prog.size() ? exp_prog.pop_front() : 'x,
				prog_err_o);
		if (reg_rvalid_o === 1'b1)
			check("reg_rdata", exp_reg.size() ? exp_reg.pop_front() : 'x,
				reg_rdata_o);
		if (rd_valid_o === 1'b1)
		begin
			// Data after a double error is not defined; flags only then
			if (exp_dc.size() && exp_dc.pop_front())
				check("rd_flags", exp_rd.pop_front() >> 128, rd_flags_o);
			else
				check("rd", exp_rd.size() ? exp_rd.pop_front() : 'x,
					{rd_flags_o, rd_data_o});
		end
	end

	task automatic prog(input int u, input logic [15:0] m, input logic err);
		@(posedge ref_clk_i);
		prog_valid_i <= 1'b1;
		prog_addr_i  <= HI | 32'(u << 4);
		prog_data_i  <= r128();
		prog_mask_i  <= m;
		exp_prog.push_back(err);
		@(posedge ref_clk_i);
		prog_valid_i <= 1'b0;
		// Let the line store commit before any read
		@(posedge ref_clk_i);
	endtask : prog

	task automatic rd(input int u, input logic [127:0] f, input logic [2:0] fl);
		@(posedge ref_clk_i);
		rd_valid_i <= 1'b1;
		rd_addr_i  <= HI | 32'(u << 4);
		flip       <= f;
		exp_dc.push_back(fl[2]);
		exp_rd.push_back({fl, fl[0] ? M.line_q[u] ^ f : M.line_q[u]});
		@(posedge ref_clk_i);
		rd_valid_i <= 1'b0;
	endtask : rd

	task automatic er(input int u);
		@(posedge ref_clk_i);
		erase_valid_i <= 1'b1;
		erase_addr_i  <= 32'(u << 4);
		@(posedge ref_clk_i);
		erase_valid_i <= 1'b0;
	endtask : er

	task automatic regrd(input logic [31:0] a, input logic [7:0] e);
		@(posedge ref_clk_i);
		reg_rd_i   <= 1'b1;
		reg_addr_i <= a;
		exp_reg.push_back(e);
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
	endtask : regrd

	task automatic summarize();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize

	// Main sequence
	initial
	begin
		repeat (12) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		foreach (ofs[i])
			regrd(ofs[i], 8'h00);
		$display("test reset_regs done");
		prog(1, 16'hffff, 1'b0);
		rd(1, '0, 3'b000);
		rd(1, 128'h1 << 17, 3'b010);
		rd(1, 128'h3 << 90, 3'b100);
		regrd(ecc_pkg::OFS_STATUS, 8'h08);
		regrd(ecc_pkg::OFS_COUNT_LO, 8'h02);
		regrd(ecc_pkg::OFS_COUNT_HI, 8'h00);
		regrd(ecc_pkg::OFS_TRAP_B0, 8'h15);
		regrd(ecc_pkg::OFS_TRAP_B1, 8'h00);
		regrd(ecc_pkg::OFS_TRAP_B2, 8'h12);
		regrd(ecc_pkg::OFS_TRAP_B3, 8'h03);
		prog(1, 16'hffff, 1'b1);
		prog(2, 16'h0001, 1'b1);
		rd(2, '0, 3'b000);
		$display("test double_mode done");
		er(0);
		er(4);
		@(posedge ref_clk_i);
		dbl_mode_i <= 1'b0;
		prog(3, 16'h000f, 1'b0);
		rd(3, 128'h1 << 70, 3'b010);
		prog(3, 16'h0f00, 1'b0);
		rd(3, 128'h1 << 70, 3'b001);
		regrd(ecc_pkg::OFS_STATUS, 8'h01);
		er(3);
		prog(3, 16'hffff, 1'b0);
		rd(3, 128'h1 << 127, 3'b010);
		prog(5, 16'hffff, 1'b0);
		@(posedge ref_clk_i);
		dbl_mode_i <= 1'b1;
		rd(5, '0, 3'b001);
		$display("test single_mode done");
		// Mid-run reset: array data survives, trap and counter re-arm
		@(posedge ref_clk_i);
		srst_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		regrd(ecc_pkg::OFS_COUNT_LO, 8'h00);
		regrd(ecc_pkg::OFS_TRAP_B0, 8'h00);
		prog(6, 16'hffff, 1'b0);
		rd(6, 128'h1 << 5, 3'b010);
		regrd(ecc_pkg::OFS_TRAP_B0, 8'h65);
		regrd(ecc_pkg::OFS_COUNT_LO, 8'h01);
		$display("test reset_rearm done");
		repeat (4) @(posedge ref_clk_i);
		check("queues", '0,
			exp_prog.size() + exp_rd.size() + exp_reg.size());
		summarize();
	end

	// Whole run needs little more than a hundred cycles
	initial
	begin
		repeat (5000) @(posedge ref_clk_i);
		mismatches++;
		summarize();
	end
endmodule : flash_array_secded_ecc_tb_top
